// >>> logic/aht_angle_turns.v
`timescale 1ns/1ps
`include "aht_defs.vh"
// Summary of operation
// R1: window width is setting times 360/16384 degrees, at 14-bit resolution.
// R2: held angle readable at 12-bit resolution in its own register.
// R3: forward motion passes the angle straight to the held output.
// R4: on reversal the output holds until the angle leaves the window.
// R5: leaving on the tail side flips the head and the direction.
// R6: direction flag reads 0 for increasing, 1 for decreasing.
// R7: reset or self test: increasing direction, window behind start angle.
// R8: turns source select 0 takes the zero-crossing path angle.
// R9: 21-bit position: 12-bit angle plus 9 turn bits, sign-extended.
// R10: turn count is upper 10 bits, or upper 12 in 45-degree mode.
// R11: turn count range -512..511, or -2048..2047 in 45-degree mode.
// R12: low bits latched as sub-turn field when the turn count is read.
// R13: turn count readout sits at serial address 0x2c.
// R14: start options 00 and 01 clear the position at power-up.
// R15: start option 10 loads the measured angle at power-up.
// R16: start option 11 loads distance past the lower step boundary.
// R17: start option comes from nonvolatile word 0x1d bits 19:18.
// R18: in 180-degree mode one counted turn is 2048 codes.
// R19: one full rotation equals 4096 position codes.
// R20: each sample after the first adds the signed shortest-path delta to the position.
// R21: hysteresis follows the compensated stream, once per new sample.
module aht_angle_turns #(
  parameter HW = `AHT_HYS_W,
  parameter AW = `AHT_ANG_W,
  parameter PW = `AHT_POS_W,
  parameter WW = `AHT_WIN_W,
  parameter RW = `AHT_REG_W
) (
  // clock and reset
  input  wire          clock,
  input  wire          rst_n,
  // compensated angle stream
  input  wire [HW-1:0] comp_angle,
  input  wire          comp_valid,
  // zero-crossing path angle stream
  input  wire [AW-1:0] zero_crossing_path,
  input  wire          zero_crossing_valid,
  // logic self test finished, one-cycle pulse
  input  wire          logic_self_test,
  // configuration levels
  input  wire [WW-1:0] window_width_setting,
  input  wire          step_45_select,
  input  wire          turns_src_sel,
  // nonvolatile configuration word load
  input  wire [7:0]    nv_addr,
  input  wire [23:0]   nv_data,
  input  wire          nv_load,
  // primary register read port
  input  wire [7:0]    reg_addr,
  input  wire          reg_rd,
  output reg  [RW-1:0] reg_rdata_q,
  output reg           reg_rvalid_q,
  // direct result outputs
  output reg  [AW-1:0] held_angle_readout,
  output reg           rotation_direction_flag,
  output reg  [RW-1:0] turn_count_q
);

  // sign-extend a turn field to the register width
  function [RW-1:0] turns_of;
    input [PW-1:0] pos;
    input          s45;
    begin
      if (s45)
        turns_of = {{(RW-(PW-`AHT_STEP45_BITS)){pos[PW-1]}},
                    pos[PW-1:`AHT_STEP45_BITS]};
      else
        turns_of = {{(RW-(PW-`AHT_STEP180_BITS)){pos[PW-1]}},
                    pos[PW-1:`AHT_STEP180_BITS]};
    end
  endfunction

  // sub-turn field of the position, zero-extended
  function [RW-1:0] sub_of;
    input [PW-1:0] pos;
    input          s45;
    begin
      if (s45)
        sub_of = {{(RW-`AHT_STEP45_BITS){1'b0}},
                  pos[`AHT_STEP45_BITS-1:0]};
      else
        sub_of = {{(RW-`AHT_STEP180_BITS){1'b0}},
                  pos[`AHT_STEP180_BITS-1:0]};
    end
  endfunction

  wire [HW-1:0] held_w;
  wire          dir_w;
  wire [PW-1:0] pos_w;
  wire          pos_primed_w;
  reg  [1:0]    start_opt_q;
  reg  [AW-1:0] src_angle_w;
  reg           src_vld_w;
  reg  [RW-1:0] subturn_q;
  reg  [RW-1:0] rdata_d;
  wire [RW-1:0] turns_now_w;

  // R17 start option capture
  // later loads still update the option, but it only matters before the
  // first sample; after that the running sum no longer looks at it
  always @(posedge clock) begin
    if (!rst_n)
      start_opt_q <= `AHT_START_ZERO0;
    else if (nv_load && nv_addr == `AHT_NV_START_ADR)
      start_opt_q <= nv_data[`AHT_NV_START_HI:`AHT_NV_START_LO];
  end

  // turns source selection
  always @* begin
    // R8 zero-crossing source
    if (!turns_src_sel) begin
      src_angle_w = zero_crossing_path;
      src_vld_w   = zero_crossing_valid;
    end else begin
      src_angle_w = comp_angle[HW-1:HW-AW];
      src_vld_w   = comp_valid;
    end
  end

  // R1 window at 14 bits
  // R21 compensated stream input
  aht_hyst_core #(
    .HW (HW),
    .WW (WW)
  ) u_hyst (
    .clock     (clock),
    .rst_n     (rst_n),
    .restart   (logic_self_test),
    .angle_in  (comp_angle),
    .angle_vld (comp_valid),
    .win_width (window_width_setting),
    .held_q    (held_w),
    .dir_q     (dir_w)
  );

  // R9 R19 position word
  aht_pos_accum #(
    .AW (AW),
    .PW (PW)
  ) u_accum (
    .clock     (clock),
    .rst_n     (rst_n),
    .angle_in  (src_angle_w),
    .angle_vld (src_vld_w),
    .start_opt (start_opt_q),
    .step45    (step_45_select),
    .pos_q     (pos_w),
    .primed_q  (pos_primed_w)
  );

  // R10 R11 R18 turn field
  assign turns_now_w = turns_of(pos_w, step_45_select);

  // mirror results into output flops, one cycle behind the cores
  always @(posedge clock) begin
    if (!rst_n) begin
      held_angle_readout      <= {AW{1'b0}};
      rotation_direction_flag <= `AHT_DIR_INC;
      turn_count_q            <= {RW{1'b0}};
    end else begin
      // R2 12-bit held angle
      held_angle_readout      <= held_w[HW-1:HW-AW];
      // R6 direction flag
      rotation_direction_flag <= dir_w;
      turn_count_q            <= turns_now_w;
    end
  end

  // read data decode; unmapped offsets answer zero
  always @* begin
    case (reg_addr)
      `AHT_OFF_HELD:    rdata_d = {{(RW-AW){1'b0}}, held_w[HW-1:HW-AW]};
      `AHT_OFF_STATUS:  rdata_d = {{(RW-2){1'b0}}, pos_primed_w, dir_w};
      // R13 turns at 0x2c
      `AHT_OFF_TURNS:   rdata_d = turns_now_w;
      `AHT_OFF_SUBTURN: rdata_d = subturn_q;
      default:          rdata_d = {RW{1'b0}};
    endcase
  end

  // read answer one cycle after the strobe
  always @(posedge clock) begin
    if (!rst_n) begin
      reg_rdata_q  <= {RW{1'b0}};
      reg_rvalid_q <= 1'b0;
    end else begin
      reg_rvalid_q <= reg_rd;
      if (reg_rd)
        reg_rdata_q <= rdata_d;
    end
  end

  // sub-turn snapshot taken with the turn count read, so both halves
  // rebuild one common position even while the shaft keeps turning
  always @(posedge clock) begin
    if (!rst_n)
      subturn_q <= {RW{1'b0}};
    // R12 latch on turns read
    else if (reg_rd && reg_addr == `AHT_OFF_TURNS)
      subturn_q <= sub_of(pos_w, step_45_select);
  end

endmodule // aht_angle_turns

// >>> logic/aht_defs.vh
`ifndef AHT_DEFS_VH
`define AHT_DEFS_VH

// compensated angle and readout resolutions
`define AHT_HYS_W        14
`define AHT_ANG_W        12
`define AHT_POS_W        21
`define AHT_WIN_W        6
`define AHT_REG_W        16

// one full turn in position codes, and the step sizes per mode
`define AHT_TURN_CODES   13'h1000
`define AHT_STEP180_BITS 11
`define AHT_STEP45_BITS  9

// primary serial register offsets
`define AHT_OFF_HELD     8'h20
`define AHT_OFF_STATUS   8'h22
`define AHT_OFF_TURNS    8'h2c
`define AHT_OFF_SUBTURN  8'h2e

// status field position
`define AHT_STA_DIR_BIT  0

// nonvolatile word holding the start option, and its field
`define AHT_NV_START_ADR 8'h1d
`define AHT_NV_START_HI  19
`define AHT_NV_START_LO  18

// start option encodings
`define AHT_START_ZERO0  2'b00
`define AHT_START_ZERO1  2'b01
`define AHT_START_ANGLE  2'b10
`define AHT_START_STEP   2'b11

// direction flag encodings; increasing is the reset value
`define AHT_DIR_INC      1'b0
`define AHT_DIR_DEC      1'b1

`endif

// >>> logic/aht_hyst_core.v
`timescale 1ns/1ps
`include "aht_defs.vh"

// hysteresis window on the 14-bit compensated angle
module aht_hyst_core #(
  parameter HW = `AHT_HYS_W,
  parameter WW = `AHT_WIN_W
) (
  // clock and reset
  input  wire          clock,
  input  wire          rst_n,
  // restart after self test
  input  wire          restart,
  // angle stream
  input  wire [HW-1:0] angle_in,
  input  wire          angle_vld,
  input  wire [WW-1:0] win_width,
  // results
  output reg  [HW-1:0] held_q,
  output reg           dir_q
);

  reg           primed_q;
  wire [HW-1:0] diff_w;
  wire          ahead_w;
  wire [HW-1:0] mag_w;
  wire          out_w;

  // modular distance from the held head to the new sample
  assign diff_w  = angle_in - held_q;
  // forward in the current direction means the head advances
  assign ahead_w = (dir_q == `AHT_DIR_INC) ? ~diff_w[HW-1] & |diff_w
                                           : diff_w[HW-1];
  assign mag_w   = diff_w[HW-1] ? (~diff_w + {{(HW-1){1'b0}}, 1'b1})
                                : diff_w;
  // left the window on the tail side
  assign out_w   = ~ahead_w & (mag_w > {{(HW-WW){1'b0}}, win_width});

  // head, direction and first-sample capture
  always @(posedge clock) begin
    if (!rst_n || restart) begin
      held_q   <= {HW{1'b0}};
      dir_q    <= `AHT_DIR_INC;
      primed_q <= 1'b0;
    end else if (angle_vld) begin
      if (!primed_q) begin
        // R7 window behind start
        held_q   <= angle_in;
        dir_q    <= `AHT_DIR_INC;
        primed_q <= 1'b1;
      end else if (ahead_w) begin
        // R3 pass through forward
        held_q <= angle_in;
      end else if (out_w) begin
        // R5 flip the head
        held_q <= angle_in;
        dir_q  <= ~dir_q;
      end
      // R4 hold inside window
    end
  end

endmodule // aht_hyst_core

// >>> logic/aht_pos_accum.v
`timescale 1ns/1ps
`include "aht_defs.vh"

// 21-bit signed position accumulator with start options
module aht_pos_accum #(
  parameter AW = `AHT_ANG_W,
  parameter PW = `AHT_POS_W
) (
  // clock and reset
  input  wire          clock,
  input  wire          rst_n,
  // angle stream and configuration
  input  wire [AW-1:0] angle_in,
  input  wire          angle_vld,
  input  wire [1:0]    start_opt,
  input  wire          step45,
  // accumulated position
  output reg  [PW-1:0] pos_q,
  output reg           primed_q
);

  reg  [AW-1:0] prev_q;
  wire [AW-1:0] delta_w;
  reg  [PW-1:0] init_d;

  // shortest path: wraps through the 12-bit modulo difference
  assign delta_w = angle_in - prev_q;

  // start value chosen from the option
  always @* begin
    case (start_opt)
      `AHT_START_ANGLE: init_d = {{(PW-AW){1'b0}}, angle_in};
      `AHT_START_STEP: begin
        if (step45)
          init_d = {{(PW-`AHT_STEP45_BITS){1'b0}},
                    angle_in[`AHT_STEP45_BITS-1:0]};
        else
          init_d = {{(PW-`AHT_STEP180_BITS){1'b0}},
                    angle_in[`AHT_STEP180_BITS-1:0]};
      end
      default: init_d = {PW{1'b0}};
    endcase
  end

  // power-up load, then running sum of signed steps
  always @(posedge clock) begin
    if (!rst_n) begin
      pos_q    <= {PW{1'b0}};
      prev_q   <= {AW{1'b0}};
      primed_q <= 1'b0;
    end else if (angle_vld) begin
      prev_q <= angle_in;
      if (!primed_q) begin
        // R14 R15 R16 start value
        pos_q    <= init_d;
        primed_q <= 1'b1;
      end else begin
        // R20 signed delta added
        pos_q <= pos_q + {{(PW-AW){delta_w[AW-1]}}, delta_w};
      end
    end
  end

endmodule // aht_pos_accum

// >>> verif/aht_angle_turns_checker.sv
`timescale 1ns/1ps
module aht_angle_turns_checker (
  // clock and reset
  input wire        clock,
  input wire        rst_n,
  // requests
  input wire        comp_valid,
  input wire        zero_crossing_valid,
  input wire        logic_self_test,
  input wire        step_45_select,
  input wire [7:0]  reg_addr,
  input wire        reg_rd,
  // results
  input wire [15:0] reg_rdata_q,
  input wire        reg_rvalid_q,
  input wire [11:0] held_angle_readout,
  input wire        rotation_direction_flag,
  input wire [15:0] turn_count_q
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // outputs move two edges after a sample or a self test; turn count also follows a step mode change
  property p_rd; reg_rd |=> reg_rvalid_q; endproperty
  a_rd: assert property (p_rd) else $error("read unanswered");
  property p_rv; reg_rvalid_q |-> $past(reg_rd); endproperty
  a_rv: assert property (p_rv) else $error("stray rvalid");
  property p_trg; reg_rd && reg_addr == 8'h2c |=> reg_rdata_q ==
    turn_count_q || reg_rdata_q == $past(turn_count_q); endproperty
  a_trg: assert property (p_trg) else $error("turns reg bad");
  // readout flops and read data both sample the core on the strobe edge
  property p_hrg; reg_rd && reg_addr == 8'h20 |=> reg_rdata_q ==
    {4'h0, held_angle_readout}; endproperty
  a_hrg: assert property (p_hrg) else $error("held reg bad");
  property p_sta; reg_rd && reg_addr == 8'h22 |=>
    reg_rdata_q[0] == rotation_direction_flag; endproperty
  a_sta: assert property (p_sta) else $error("status dir bad");
  property p_hch; $changed(held_angle_readout) |-> $past(comp_valid, 2)
    || $past(logic_self_test, 2) || $past(logic_self_test); endproperty
  a_hch: assert property (p_hch) else $error("held moved alone");
  property p_dch; $changed(rotation_direction_flag) |->
    $past(comp_valid, 2) || $past(logic_self_test, 2); endproperty
  a_dch: assert property (p_dch) else $error("dir moved alone");
  property p_st; logic_self_test |-> ##2 !rotation_direction_flag;
  endproperty
  a_st: assert property (p_st) else $error("self test dir");
  // a step mode change reslices the position without any sample
  property p_tch; $changed(turn_count_q) |-> $past(comp_valid, 2)
    || $past(zero_crossing_valid, 2)
    || $past(step_45_select) != $past(step_45_select, 2); endproperty
  a_tch: assert property (p_tch) else $error("turns moved alone");
  c_trd: cover property (reg_rd && reg_addr == 8'h2c);
  c_flip: cover property ($rose(rotation_direction_flag));
  c_st: cover property (logic_self_test);
endmodule // aht_angle_turns_checker

bind aht_angle_turns aht_angle_turns_checker u_chk (.*);

// >>> verif/aht_angle_turns_test.sv
`timescale 1ns/1ps
module aht_angle_turns_test;
  logic        clock = 1'b0, rst_n = 1'b0, comp_valid = 1'b0;
  logic [13:0] comp_angle = 14'h0000, ang;
  logic [11:0] zero_crossing_path = 12'h000;
  logic        zero_crossing_valid = 1'b0, logic_self_test = 1'b0;
  logic [5:0]  window_width_setting = 6'h08;
  logic        step_45_select = 1'b0, turns_src_sel = 1'b1, nv_load = 1'b0;
  logic [7:0]  nv_addr = 8'h00;
  logic [23:0] nv_data = 24'h000000;
  wire  [7:0]  reg_addr;
  wire         reg_rd, reg_rvalid_q, rotation_direction_flag;
  wire  [15:0] reg_rdata_q, turn_count_q;
  wire  [11:0] held_angle_readout;
  // bench copy of head, direction and position
  logic [13:0] head;
  logic        dir, hp, pp;
  logic [20:0] pos;
  logic [11:0] prev;
  logic [1:0]  opt;
  logic [15:0] v, sub;
  int          err_total = 0, tests_run = 0;

  always #2 clock = ~clock;
  aht_angle_turns u_dut (.*);
  aht_host_model u_host (.*);

  task chk(input string nm, input logic [15:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask
  function logic [15:0] turns(input logic [20:0] p, input logic s);
    turns = s ? {{4{p[20]}}, p[20:9]} : {{6{p[20]}}, p[20:11]};
  endfunction
  task summarize;
    if (err_total == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task do_reset;
    rst_n = 1'b0;
    repeat (4) @(negedge clock);
    rst_n = 1'b1;
    {hp, pp, dir, opt} = 5'h00;
  endtask
  task nvset(input [7:0] a, input [1:0] o);
    @(negedge clock);
    nv_addr = a;
    nv_data = $urandom;
    nv_data[19:18] = o;
    nv_load = 1'b1;
    if (a == 8'h1d) opt = o;
    @(negedge clock);
    nv_load = 1'b0;
  endtask
  task rchk(input [7:0] a, input [15:0] e);
    u_host.rd(a, v);
    chk("rdata", v, e);
  endtask
  task samp(input [13:0] a, input [11:0] z, input s, input s45);
    logic signed [13:0] sd;
    logic [11:0] t, dt;
    @(negedge clock);
    {comp_angle, zero_crossing_path, turns_src_sel} = {a, z, s};
    {comp_valid, zero_crossing_valid, step_45_select} = {2'b11, s45};
    sd = a - head;
    if (dir) sd = -sd;
    if (!hp) {head, dir, hp} = {a, 2'b01};
    else if (sd > 0 || -sd > window_width_setting) begin
      if (sd < 0) dir = ~dir;
      head = a;
    end
    // position start value and signed steps
    t = s ? a[13:2] : z;
    dt = t - prev;
    if (pp) pos = pos + {{9{dt[11]}}, dt};
    else if (opt == 2'b10) pos = 21'(t);
    else if (opt == 2'b11) pos = 21'(s45 ? t[8:0] : t[10:0]);
    else pos = 21'h0;
    {pp, prev} = {1'b1, t};
    @(negedge clock);
    {comp_valid, zero_crossing_valid} = 2'b00;
    @(negedge clock);
    chk("held", {4'h0, held_angle_readout}, {4'h0, head[13:2]});
    chk("dir", {15'h0, rotation_direction_flag}, {15'h0, dir});
    chk("turns", turn_count_q, turns(pos, s45));
  endtask

  // a hang is cut short well past the expected run length
  initial begin
    #200000;
    err_total++;
    summarize;
  end
  initial begin
    v = $urandom(32'hc633);
    do_reset;
    nvset(8'h1c, 2'b11);
    nvset(8'h1d, 2'b10);
    samp(14'd12288, 12'h000, 1'b1, 1'b0);
    rchk(8'h2c, 16'h0001);
    sub = {5'h00, pos[10:0]};
    rchk(8'h20, 16'd3072);
    rchk(8'h30, 16'h0000);
    samp(14'd12400, 12'h000, 1'b1, 1'b0);
    rchk(8'h2e, sub);
    // random walk across the 0/360 seam with self tests mixed in
    ang = 14'h3ff0;
    repeat (300) begin
      ang = ang + 14'($urandom_range(0, 80)) - 14'd40;
      if ($urandom_range(0, 31) == 0) window_width_setting = $urandom;
      if ($urandom_range(0, 40) == 0) begin
        logic_self_test = 1'b1;
        @(negedge clock);
        logic_self_test = 1'b0;
        {hp, dir} = 2'b00;
      end
      samp(ang, ang[13:2] + 12'($urandom_range(0, 8)),
           1'($urandom), 1'($urandom));
      rchk(8'h22, {14'h0, pp, dir});
    end
    // every start option, 45-degree step mode for the odd options, 180-degree for the even
    for (int o = 0; o < 4; o++) begin
      do_reset;
      nvset(8'h1d, o[1:0]);
      samp(14'd777, 12'd3500, 1'b0, o[0]);
      rchk(8'h2c, turns(pos, o[0]));
      sub = o[0] ? {7'h00, pos[8:0]} : {5'h00, pos[10:0]};
      rchk(8'h2e, sub);
    end
    summarize;
  end
endmodule // aht_angle_turns_test

// >>> verif/aht_host_model.sv
`timescale 1ns/1ps
module aht_host_model (
  // clock
  input  wire        clock,
  // register read port
  output reg  [7:0]  reg_addr,
  output reg         reg_rd,
  input  wire [15:0] reg_rdata_q,
  input  wire        reg_rvalid_q
);
  initial begin
    reg_addr = 8'h00;
    reg_rd = 1'b0;
  end
  // one read; address then inverted so a stale value never matches
  task rd(input [7:0] a, output [15:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clock);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rvalid_q ? reg_rdata_q : 16'hxxxx;
  endtask
endmodule // aht_host_model
